// file: verilog/delay_timer_pkg.sv
// Purpose: Shared constants and types for the single-bit delay timer function.
// Assumes: One 20 MHz system clock; elapsed time counts in ticks of a shared time base.
// Notes: Every width, encoding, reset value and timing count lives here.

package delay_timer_pkg;

   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int TIME_W = 16;
   localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
   localparam logic [TIME_W-1:0] TIME_MAX = 16'hffff;
   localparam logic [TIME_W-1:0] TIME_ONE = 16'h0001;

   // ************************************************************
   // Time base: one tick every 10 ms at a 50 ns clock period
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_MS = 10;
   localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 24;

   // ************************************************************
   // Function modes (Gray order) and timing phases (Gray order)
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_OFF_DELAY = 2'h0,
      MODE_ON_OFF = 2'h1,
      MODE_RETENTIVE = 2'h3,
      MODE_WIPING = 2'h2
   } timer_mode_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_ON_WAIT = 2'h1,
      PH_HIGH = 2'h3,
      PH_OFF_WAIT = 2'h2
   } timer_phase_t;

   // Duration source selection
   localparam logic SRC_FIXED = 1'b0;
   localparam logic SRC_LINKED = 1'b1;

endpackage : delay_timer_pkg

// file: verilog/delay_timer.sv
// Purpose: One configurable single-bit delay timer function with four modes.
// Assumes: trigger_in and kill_in come from logic on core_clk; no synchronisers needed.
// Notes: Output level and elapsed time are registered; the time base is generated here.
//
// What this block does
// - Off-delay: rising trigger sets output immediately
// - Off-delay: falling trigger restarts time, output holds
// - Off-delay: each further pulse restarts the time
// - Off-delay: kill clears time and output
// - On/off: rise starts on-hold, output rises after
// - On/off: early fall discards the on count
// - On/off: fall starts off-hold, output drops after
// - On/off: early rise discards off count, stays high
// - Durations fixed or taken from linked value
// - Retentive: output sets at expiry regardless of trigger
// - Retentive: later pulses leave elapsed time alone
// - Retentive: only kill, or reset without retention, clears output and time
// - Kill takes precedence over trigger
// - Retention chooses clear or keep across reset
// - Wiping: rise sets output, starts time at zero
// - Wiping: output drops when time reaches duration
// - Wiping: early fall drops output at once

`timescale 1ns/1ps
`default_nettype none

module delay_timer #(
   parameter int TICK_DIV = delay_timer_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Configuration
   input wire delay_timer_pkg::timer_mode_t mode,
   input wire logic retain_en,
   input wire logic on_src_sel,
   input wire logic off_src_sel,
   input wire logic [delay_timer_pkg::TIME_W-1:0] cfg_on_hold,
   input wire logic [delay_timer_pkg::TIME_W-1:0] cfg_off_hold,
   input wire logic [delay_timer_pkg::TIME_W-1:0] linked_on_value,
   input wire logic [delay_timer_pkg::TIME_W-1:0] linked_off_value,
   // Function inputs from surrounding logic
   input wire logic trigger_in,
   input wire logic kill_in,
   // Function outputs
   output logic pulse_level,
   output logic [delay_timer_pkg::TIME_W-1:0] elapsed_time,
   output logic time_tick
);
   import delay_timer_pkg::*;

   // ************************************************************
   // Time base
   // ************************************************************
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV - 1);

   logic [TICK_CNT_W-1:0] tick_cnt;
   wire tick_wrap = (tick_cnt == TICK_LAST);

   // Free-running divider; every timer on the same base sees the same tick
   always_ff @(posedge core_clk)
   begin
      if (rst)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
   end

   // Elapsed time only moves on this one-cycle strobe
   assign time_tick = tick_wrap;

   // ************************************************************
   // Edge detection and duration selection
   // ************************************************************
   logic trig_prev;
   timer_phase_t phase;

   // Edges compare against the previous cycle; prev resets low like an open input
   wire trig_rise = trigger_in & ~trig_prev;
   wire trig_fall = ~trigger_in & trig_prev;

   function automatic logic [TIME_W-1:0] pick_dur(input logic sel,
         input logic [TIME_W-1:0] fixed_v, input logic [TIME_W-1:0] linked_v);
      pick_dur = (sel == SRC_LINKED) ? linked_v : fixed_v;
   endfunction : pick_dur

   function automatic logic [TIME_W-1:0] bump(input logic [TIME_W-1:0] t);
      bump = (t == TIME_MAX) ? t : t + TIME_ONE;
   endfunction : bump

   // Single-duration modes use the on-hold source; linked values follow live
   wire [TIME_W-1:0] on_dur = pick_dur(on_src_sel, cfg_on_hold, linked_on_value);
   wire [TIME_W-1:0] off_dur = pick_dur(off_src_sel, cfg_off_hold, linked_off_value);

   // Compare with >= so a linked duration that shrinks below the count still expires
   wire on_done = (elapsed_time >= on_dur);
   wire off_done = (elapsed_time >= off_dur);
   wire [TIME_W-1:0] elapsed_inc = time_tick ? bump(elapsed_time) : elapsed_time;

   // ************************************************************
   // Next-state decode
   // ************************************************************
   timer_phase_t next_phase;
   logic next_level;
   logic [TIME_W-1:0] next_elapsed;

   always_comb
   begin
      next_phase = phase;
      next_level = pulse_level;
      next_elapsed = elapsed_time;
      if (kill_in)
      begin
         // Kill beats any trigger edge seen in the same cycle
         next_phase = PH_IDLE;
         next_level = 1'b0;
         next_elapsed = TIME_ZERO;
      end
      else
      begin
         case (mode)
            MODE_OFF_DELAY:
            begin
               if (trig_rise)
               begin
                  next_phase = PH_HIGH;
                  next_level = 1'b1;
               end
               // Level test: after a retained reset the edge memory is low and a fall is lost
               else if (phase == PH_HIGH && !trigger_in)
               begin
                  next_phase = PH_OFF_WAIT;
                  next_level = 1'b1;
                  next_elapsed = TIME_ZERO;
               end
               else if (phase == PH_OFF_WAIT)
               begin
                  if (on_done)
                  begin
                     next_phase = PH_IDLE;
                     next_level = 1'b0;
                  end
                  else
                     next_elapsed = elapsed_inc;
               end
            end
            MODE_ON_OFF:
            begin
               case (phase)
                  PH_IDLE:
                     if (trigger_in)
                     begin
                        next_phase = PH_ON_WAIT;
                        next_elapsed = TIME_ZERO;
                     end
                  PH_ON_WAIT:
                     if (!trigger_in)
                     begin
                        next_phase = PH_IDLE;
                        next_elapsed = TIME_ZERO;
                     end
                     else if (on_done)
                     begin
                        next_phase = PH_HIGH;
                        next_level = 1'b1;
                     end
                     else
                        next_elapsed = elapsed_inc;
                  PH_HIGH:
                     if (!trigger_in)
                     begin
                        next_phase = PH_OFF_WAIT;
                        next_elapsed = TIME_ZERO;
                     end
                  PH_OFF_WAIT:
                     if (trigger_in)
                     begin
                        next_phase = PH_HIGH;
                        next_elapsed = TIME_ZERO;
                     end
                     else if (off_done)
                     begin
                        next_phase = PH_IDLE;
                        next_level = 1'b0;
                     end
                     else
                        next_elapsed = elapsed_inc;
                  default:
                     next_phase = PH_IDLE;
               endcase
            end
            MODE_RETENTIVE:
            begin
               // Once started only kill, or reset without retention, ends it; trigger is ignored afterwards
               if (phase == PH_IDLE && trig_rise)
               begin
                  next_phase = PH_ON_WAIT;
                  next_elapsed = TIME_ZERO;
               end
               else if (phase == PH_ON_WAIT)
               begin
                  if (on_done)
                  begin
                     next_phase = PH_HIGH;
                     next_level = 1'b1;
                  end
                  else
                     next_elapsed = elapsed_inc;
               end
            end
            MODE_WIPING:
            begin
               // Only an idle relay starts; a retained pulse resumes instead of restarting
               if (phase == PH_IDLE && trig_rise)
               begin
                  next_phase = PH_ON_WAIT;
                  next_level = 1'b1;
                  next_elapsed = TIME_ZERO;
               end
               else if (phase == PH_ON_WAIT)
               begin
                  if (!trigger_in)
                  begin
                     next_phase = PH_IDLE;
                     next_level = 1'b0;
                  end
                  else if (on_done)
                  begin
                     next_phase = PH_IDLE;
                     next_level = 1'b0;
                  end
                  else
                     next_elapsed = elapsed_inc;
               end
            end
            default:
               next_phase = PH_IDLE;
         endcase
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************
   // Reset stands for power return: retained timers resume where they stopped
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         trig_prev <= 1'b0;
         if (!retain_en)
         begin
            phase <= PH_IDLE;
            pulse_level <= 1'b0;
            elapsed_time <= TIME_ZERO;
         end
      end
      else
      begin
         trig_prev <= trigger_in;
         phase <= next_phase;
         pulse_level <= next_level;
         elapsed_time <= next_elapsed;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_live_rise;
      trig_rise && !kill_in;
   endsequence

   sequence s_live_fall;
      trig_fall && !kill_in;
   endsequence

   chk_off_rise_high: assert property (
      (mode == MODE_OFF_DELAY) and s_live_rise |=> pulse_level)
      else $error("off-delay output did not rise with trigger");

   chk_off_fall_restart: assert property (
      (mode == MODE_OFF_DELAY && phase == PH_HIGH) and s_live_fall
      |=> pulse_level && elapsed_time == TIME_ZERO)
      else $error("off-delay fall did not restart time");

   chk_kill_clears: assert property (
      kill_in |=> !pulse_level && elapsed_time == TIME_ZERO && phase == PH_IDLE)
      else $error("kill did not clear timer");

   chk_kill_over_trig: assert property (
      kill_in && trig_rise |=> !pulse_level ##1 (!kill_in && !trig_rise) [*1] |-> !pulse_level)
      else $error("trigger beat kill");

   chk_on_abort: assert property (
      mode == MODE_ON_OFF && phase == PH_ON_WAIT && !trigger_in && !kill_in
      |=> phase == PH_IDLE && !pulse_level)
      else $error("on-hold not discarded on early fall");

   chk_on_expire: assert property (
      mode == MODE_ON_OFF && phase == PH_ON_WAIT && trigger_in && on_done && !kill_in
      |=> pulse_level)
      else $error("on-hold expiry did not raise output");

   chk_off_return: assert property (
      mode == MODE_ON_OFF && phase == PH_OFF_WAIT && trigger_in && !kill_in
      |=> phase == PH_HIGH && pulse_level)
      else $error("off-hold not discarded on early rise");

   chk_ret_hold: assert property (
      mode == MODE_RETENTIVE && pulse_level && !kill_in && $stable(mode)
      |=> pulse_level && $stable(elapsed_time))
      else $error("retentive timer changed without kill");

   chk_wipe_start: assert property (
      (mode == MODE_WIPING && phase == PH_IDLE) and s_live_rise
      |=> pulse_level && elapsed_time == TIME_ZERO)
      else $error("wiping pulse did not start");

   chk_wipe_fall: assert property (
      (mode == MODE_WIPING) and s_live_fall |=> !pulse_level)
      else $error("wiping pulse did not end on fall");

   chk_tick_only: assert property (
      !time_tick && !trig_rise && !trig_fall && !kill_in && $stable(mode) && !$past(rst)
      && phase != PH_IDLE && phase != PH_HIGH |=> elapsed_time == $past(elapsed_time))
      else $error("elapsed time moved without a tick");

   chk_off_expire: assert property (
      mode == MODE_OFF_DELAY && phase == PH_OFF_WAIT && on_done && !trig_rise && !kill_in
      |=> !pulse_level && phase == PH_IDLE)
      else $error("off-delay output did not drop at expiry");

   chk_onoff_expire: assert property (
      mode == MODE_ON_OFF && phase == PH_OFF_WAIT && !trigger_in && off_done && !kill_in
      |=> !pulse_level && phase == PH_IDLE)
      else $error("off-hold expiry did not drop output");

   chk_ret_expire: assert property (
      mode == MODE_RETENTIVE && phase == PH_ON_WAIT && on_done && !kill_in
      |=> pulse_level)
      else $error("retentive expiry did not raise output");

   chk_wipe_expire: assert property (
      mode == MODE_WIPING && phase == PH_ON_WAIT && trigger_in && on_done && !kill_in
      |=> !pulse_level && phase == PH_IDLE)
      else $error("wiping pulse outlived its duration");

endmodule : delay_timer

`default_nettype wire

// file: testbench/trigger_source.sv
// Purpose: Model of the surrounding logic that drives the timer trigger.
// Assumes: It changes only just after the rising core_clk edge, like any logic on that clock.
// Notes: Random level changes give holds both shorter and longer than the durations.

`timescale 1ns/1ps
`default_nettype none

module trigger_source (
   // Clock
   input wire logic core_clk,
   // Control from the bench
   input wire logic run,
   // Towards the timer
   output logic trigger_in
);

   // ************************************************************
   // Trigger generator
   // ************************************************************
   initial trigger_in = 1'b0;

   // Held low while stopped, so each run begins with a clean rise
   always @(posedge core_clk)
   begin
      if (!run)
         trigger_in <= 1'b0;
      else if ($urandom % 10 == 0)
         trigger_in <= ~trigger_in;
   end

endmodule : trigger_source

`default_nettype wire

// file: testbench/delay_timer_functions_bench.sv
// Purpose: Self-checking bench for the delay timer against a cycle model.
// Assumes: Short time base (TICK_DIV small); mode changes only on the edge that releases a kill held for three cycles.
// Notes: Elapsed time is compared only where the model knows its value.

`timescale 1ns/1ps
`default_nettype none

module delay_timer_functions_bench;
   import delay_timer_pkg::*;

   // ************************************************************
   // Signals and instances
   // ************************************************************
   localparam int DIV = 4;
   logic core_clk, rst, retain_en, on_src_sel, off_src_sel, kill_in, run, go;
   timer_mode_t mode;
   logic [TIME_W-1:0] cfg_on_hold, cfg_off_hold, linked_on_value, linked_off_value;
   logic [TIME_W-1:0] elapsed_time, m_el;
   logic trigger_in, pulse_level, time_tick, m_lv, m_prev, rise, tk;
   timer_phase_t m_ph;
   int m_cnt, miscompares, n_checks;
   wire logic [TIME_W-1:0] d_on = on_src_sel ? linked_on_value : cfg_on_hold;
   wire logic [TIME_W-1:0] d_off = off_src_sel ? linked_off_value : cfg_off_hold;
   wire logic m_cmp = (m_ph == PH_ON_WAIT) || (m_ph == PH_OFF_WAIT) || (mode == MODE_RETENTIVE);

   delay_timer #(.TICK_DIV(DIV)) u_delay_timer (.core_clk(core_clk), .rst(rst), .mode(mode),
      .retain_en(retain_en), .on_src_sel(on_src_sel), .off_src_sel(off_src_sel),
      .cfg_on_hold(cfg_on_hold), .cfg_off_hold(cfg_off_hold),
      .linked_on_value(linked_on_value), .linked_off_value(linked_off_value),
      .trigger_in(trigger_in), .kill_in(kill_in), .pulse_level(pulse_level),
      .elapsed_time(elapsed_time), .time_tick(time_tick));

   trigger_source u_trigger_source (.core_clk(core_clk), .run(run), .trigger_in(trigger_in));

   // ************************************************************
   // Reference model, stepped on each rising edge with the old inputs
   // ************************************************************
   always @(posedge core_clk)
   begin
      rise = trigger_in & ~m_prev;
      tk = (m_cnt == DIV - 1);
      if (rst)
      begin
         m_cnt = 0;
         m_prev = 1'b0;
         if (!retain_en)
         begin
            m_ph = PH_IDLE;
            m_lv = 1'b0;
            m_el = TIME_ZERO;
         end
      end
      else
      begin
         m_cnt = tk ? 0 : m_cnt + 1;
         m_prev = trigger_in;
         if (kill_in)
         begin
            m_ph = PH_IDLE;
            m_lv = 1'b0;
            m_el = TIME_ZERO;
         end
         else if (mode == MODE_OFF_DELAY)
         begin
            if (m_ph == PH_IDLE)
            begin
               if (rise)
               begin
                  m_ph = PH_HIGH;
                  m_lv = 1'b1;
               end
            end
            else if (m_ph == PH_HIGH)
            begin
               if (!trigger_in)
               begin
                  m_ph = PH_OFF_WAIT;
                  m_el = TIME_ZERO;
               end
            end
            else if (rise)
               m_ph = PH_HIGH;
            else if (m_el >= d_on)
            begin
               m_ph = PH_IDLE;
               m_lv = 1'b0;
            end
            else if (tk)
               m_el = m_el + TIME_ONE;
         end
         else if (mode == MODE_ON_OFF)
         begin
            if (m_ph == PH_IDLE)
            begin
               if (trigger_in)
               begin
                  m_ph = PH_ON_WAIT;
                  m_el = TIME_ZERO;
               end
            end
            else if (m_ph == PH_ON_WAIT)
            begin
               if (!trigger_in)
               begin
                  m_ph = PH_IDLE;
                  m_el = TIME_ZERO;
               end
               else if (m_el >= d_on)
               begin
                  m_ph = PH_HIGH;
                  m_lv = 1'b1;
               end
               else if (tk)
                  m_el = m_el + TIME_ONE;
            end
            else if (m_ph == PH_HIGH)
            begin
               if (!trigger_in)
               begin
                  m_ph = PH_OFF_WAIT;
                  m_el = TIME_ZERO;
               end
            end
            else if (trigger_in)
            begin
               m_ph = PH_HIGH;
               m_el = TIME_ZERO;
            end
            else if (m_el >= d_off)
            begin
               m_ph = PH_IDLE;
               m_lv = 1'b0;
            end
            else if (tk)
               m_el = m_el + TIME_ONE;
         end
         else if (mode == MODE_RETENTIVE)
         begin
            if (m_ph == PH_IDLE)
            begin
               if (rise)
               begin
                  m_ph = PH_ON_WAIT;
                  m_el = TIME_ZERO;
               end
            end
            else if (m_ph == PH_ON_WAIT)
            begin
               if (m_el >= d_on)
               begin
                  m_ph = PH_HIGH;
                  m_lv = 1'b1;
               end
               else if (tk)
                  m_el = m_el + TIME_ONE;
            end
         end
         else if (m_ph == PH_IDLE)
         begin
            if (rise)
            begin
               m_ph = PH_ON_WAIT;
               m_lv = 1'b1;
               m_el = TIME_ZERO;
            end
         end
         else if (!trigger_in || m_el >= d_on)
         begin
            m_ph = PH_IDLE;
            m_lv = 1'b0;
         end
         else if (tk)
            m_el = m_el + TIME_ONE;
      end
   end

   // ************************************************************
   // Checking and closing
   // ************************************************************
   task automatic chk(input string nm, input logic [TIME_W-1:0] seen, input logic [TIME_W-1:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Sampled mid-cycle so the edge's updates have landed
   always @(negedge core_clk)
   begin
      if (go)
      begin
         chk("pulse_level", {15'h0000, pulse_level}, {15'h0000, m_lv});
         chk("time_tick", {15'h0000, time_tick}, {15'h0000, m_cnt == DIV - 1});
         if (m_cmp)
            chk("elapsed_time", elapsed_time, m_el);
      end
   end

   // ************************************************************
   // Clock, watchdog and stimulus
   // ************************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // The run needs about 10000 cycles; twice that means a hang
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      logic k;
      void'($urandom(32'h3ce4));
      {rst, retain_en, on_src_sel, off_src_sel, kill_in, run, go} = 7'b1000000;
      {miscompares, n_checks} = '0;
      mode = MODE_OFF_DELAY;
      {cfg_on_hold, cfg_off_hold, linked_on_value, linked_off_value} = '0;
      repeat (8) @(posedge core_clk);
      go <= 1'b1;
      // Each mode four times, with and without retention; first four passes use zero fixed durations
      for (int s = 0; s < 16; s++)
      begin
         run <= 1'b0;
         kill_in <= 1'b1;
         rst <= 1'b0;
         repeat (3) @(posedge core_clk);
         mode <= timer_mode_t'(s[1:0]);
         retain_en <= s[2];
         on_src_sel <= 1'($urandom % 2);
         off_src_sel <= 1'($urandom % 2);
         cfg_on_hold <= (s < 4) ? TIME_ZERO : 16'($urandom % 6);
         cfg_off_hold <= (s < 4) ? TIME_ZERO : 16'($urandom % 6);
         linked_on_value <= 16'($urandom % 8);
         linked_off_value <= 16'($urandom % 8);
         kill_in <= 1'b0;
         run <= 1'b1;
         repeat (600)
         begin
            @(posedge core_clk);
            k = ($urandom % 80 == 0);
            kill_in <= k;
            rst <= !k && ($urandom % 300 == 0);
         end
         // Let the last kill and reset values stand one edge before the next setup
         @(posedge core_clk);
      end
      report_and_stop();
   end

endmodule : delay_timer_functions_bench

`default_nettype wire
